// >>> verilog/pmtc_pkg.sv
// constants and types shared by the top control and event register block
package pmtc_pkg;

   // ***************************************************
   // register offsets
   // ***************************************************
   localparam logic [7:0] ADDR_DELAY = 8'h12;
   localparam logic [7:0] ADDR_SRST  = 8'h16;
   localparam logic [7:0] ADDR_CFG   = 8'h17;
   localparam logic [7:0] ADDR_EVT   = 8'h18;
   localparam logic [7:0] ADDR_EVT01 = 8'h19;
   localparam logic [7:0] ADDR_EVT23 = 8'h1a;
   localparam logic [7:0] ADDR_STAT  = 8'h1b;

   // ***************************************************
   // field layouts and reset values
   // ***************************************************
   localparam int          DLY_W       = 4;
   localparam int          ON_DLY_LSB  = 0;
   localparam int          OFF_DLY_LSB = 4;
   localparam logic [7:0]  DELAY_RST   = 8'h00;
   localparam int          SRST_BIT    = 0;
   localparam int          CFG_W       = 4;
   localparam int          CFG_SPREAD  = 0;
   localparam int          CFG_PD1     = 1;
   localparam int          CFG_PD2     = 2;
   localparam int          CFG_WSEL    = 3;
   localparam logic [3:0]  CFG_RST     = 4'h6;
   // top event flags: latched low nibble, summaries in high nibble
   localparam int          EVT_LOAD    = 0;
   localparam int          EVT_RST     = 1;
   localparam int          EVT_WARN    = 2;
   localparam int          EVT_SD      = 3;
   localparam int          EVT_SUM_LSB = 4;
   localparam int          LAT_W       = 4;
   // per-rail event bit positions
   localparam int          RE_ILIM_A   = 0;
   localparam int          RE_SC       = 1;
   localparam int          RE_PG       = 2;
   localparam int          RE_ILIM_B   = 4;
   localparam int          REVT_W      = 6;
   localparam int          STAT_WARN   = 2;
   localparam int          STAT_SD     = 3;

   // ***************************************************
   // serial link and timing
   // ***************************************************
   // slave address value is arbitrary
   localparam logic [6:0]  DEV_ADDR      = 7'h2a;
   localparam logic [3:0]  BITS_PER_BYTE = 4'h8;
   localparam int          CLK_PERIOD_NS = 4;
   localparam int          MS_NS         = 1000000;
   localparam int          MS_CYCLES     = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int          PRESC_W       = 18;
   // sync vector positions
   localparam int          SY_SCL  = 0;
   localparam int          SY_SDA  = 1;
   localparam int          SY_EN   = 2;
   localparam int          SY_UV   = 3;
   localparam int          SY_SD   = 4;
   localparam int          SY_WARN = 5;
   localparam int          SY_LOAD = 6;
   localparam int          SY_REVT = 7;
   localparam int          SYNC_W  = 13;

   typedef enum logic [2:0] {B_IDLE, B_ADDR, B_PTR, B_WR, B_RD} pmtc_bus_e;
   typedef enum logic [1:0] {R_OFF, R_ON_WAIT, R_ON, R_OFF_WAIT} pmtc_rail_e;

endpackage : pmtc_pkg

// >>> verilog/pmtc_top.sv
// top control, sequencing delays and event flags behind a two-wire serial port
// Function
// - rail held off N ms after enable rises
// - rail kept on N ms after enable falls
// - pull-down bits per enable pin, default on
// - high nibble summarizes pending rail events
// - summary bit clears when its rail's event bits read zero
// - overtemp shutdown latches and disables rail
// - shutdown flag blocks any rail enable
// - overtemp warning latched, live shown separately
// - reset flag on startup, undervoltage, soft reset
// - reset events disable rail, restore defaults
// - load measurement ready latches bit zero
// - latched low nibble cleared by writing one
// - rail event registers latch, write-one clears
module pmtc_top
   import pmtc_pkg::*;
#(
   parameter int unsigned MS_CYCLES_P = MS_CYCLES
) (
   input  wire logic                        I_CLK,
   input  wire logic                        I_RSTN,
   input  wire logic                        I_SCL,
   input  wire logic                        I_SDA_IN,
   output logic                             O_SDA_OUT,
   output logic                             O_SDA_OE_N,
   input  wire logic                        I_EN_PIN1,
   input  wire logic                        I_ANALOG_UV,
   input  wire logic                        I_OT_SD_LIVE,
   input  wire logic                        I_OT_WARN_LIVE,
   input  wire logic                        I_LOAD_DONE,
   input  wire logic [pmtc_pkg::REVT_W-1:0] I_RAIL_EVT,
   output logic                             O_MAIN_RAIL_EN,
   output logic                             O_EN_PIN1_PD,
   output logic                             O_EN_PIN2_PD,
   output logic                             O_OT_WARN_SEL,
   output logic                             O_SPREAD_EN
);
   import pmtc_pkg::*;

   localparam logic [PRESC_W-1:0] MS_LAST = PRESC_W'(MS_CYCLES_P - 1);
   // serial lines idle high: no false edge after reset
   localparam logic [SYNC_W-1:0]  SYNC_IDLE = (SYNC_W'(1) << SY_SCL) | (SYNC_W'(1) << SY_SDA);

   // ***************************************************
   // input synchronisers and edges
   // ***************************************************
   logic [SYNC_W-1:0] s1_q, s2_q, s3_q;
   wire  [SYNC_W-1:0] in_raw = {I_RAIL_EVT, I_LOAD_DONE, I_OT_WARN_LIVE, I_OT_SD_LIVE,
                                I_ANALOG_UV, I_EN_PIN1, I_SDA_IN, I_SCL};
   wire  [SYNC_W-1:0] rise   = s2_q & ~s3_q;

   always_ff @(posedge I_CLK) begin
      if (!I_RSTN) begin
         s1_q <= SYNC_IDLE;
         s2_q <= SYNC_IDLE;
         s3_q <= SYNC_IDLE;
      end else begin
         s1_q <= in_raw;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   wire scl_s     = s2_q[SY_SCL];
   wire sda_s     = s2_q[SY_SDA];
   wire scl_rise  = rise[SY_SCL];
   wire scl_fall  = ~scl_s & s3_q[SY_SCL];
   wire start_det = scl_s & s3_q[SY_SCL] & ~sda_s & s3_q[SY_SDA];
   wire stop_det  = scl_s & s3_q[SY_SCL] & sda_s & ~s3_q[SY_SDA];
   wire en_s      = s2_q[SY_EN];
   wire uv_rise   = rise[SY_UV];
   wire sd_live   = s2_q[SY_SD];
   wire warn_live = s2_q[SY_WARN];
   wire load_rise = rise[SY_LOAD];

   // ***************************************************
   // reset events
   // ***************************************************
   logic por_q, srst_pend_q, srst_pend_d;
   wire  srst_go = srst_pend_q & stop_det;
   wire  rst_all = srst_go | uv_rise;
   wire  rst_evt = ~por_q | rst_all;

   always_ff @(posedge I_CLK) begin
      if (!I_RSTN) begin
         por_q <= 1'b0;
      end else begin
         por_q <= 1'b1;
      end
   end

   // ***************************************************
   // serial slave
   // ***************************************************
   pmtc_bus_e   bst_q, bst_d;
   logic [3:0]  bcnt_q, bcnt_d;
   logic [7:0]  sh_q, sh_d, ptr_q, ptr_d, rbyte;
   logic        ack_q, ack_d, rw_q, rw_d, oe_n_q, oe_n_d, wr_en;

   always_comb begin
      bst_d  = bst_q;
      bcnt_d = bcnt_q;
      sh_d   = sh_q;
      ptr_d  = ptr_q;
      ack_d  = ack_q;
      rw_d   = rw_q;
      oe_n_d = oe_n_q;
      wr_en  = 1'b0;
      if (start_det) begin
         bst_d  = B_ADDR;
         bcnt_d = '0;
         ack_d  = 1'b0;
         oe_n_d = 1'b1;
      end else if (stop_det) begin
         bst_d  = B_IDLE;
         ack_d  = 1'b0;
         oe_n_d = 1'b1;
      end else if (scl_rise) begin
         if (bst_q == B_RD) begin
            if (!ack_q) begin
               bcnt_d = bcnt_q + 4'h1;
            end else if (sda_s) begin
               bst_d = B_IDLE;
            end
         end else if (bst_q != B_IDLE && !ack_q) begin
            sh_d   = {sh_q[6:0], sda_s};
            bcnt_d = bcnt_q + 4'h1;
         end
      end else if (scl_fall && bst_q != B_IDLE) begin
         if (bst_q == B_RD) begin
            if (ack_q || bcnt_q != BITS_PER_BYTE) begin
               oe_n_d = ack_q ? rbyte[7] : sh_q[7];
               sh_d   = ack_q ? {rbyte[6:0], 1'b0} : {sh_q[6:0], 1'b0};
               ptr_d  = ack_q ? ptr_q + 8'h01 : ptr_q;
               bcnt_d = ack_q ? 4'h0 : bcnt_q;
               ack_d  = 1'b0;
            end else begin
               oe_n_d = 1'b1;
               ack_d  = 1'b1;
               bcnt_d = '0;
            end
         end else if (!ack_q && bcnt_q == BITS_PER_BYTE) begin
            bcnt_d = '0;
            ack_d  = 1'b1;
            oe_n_d = 1'b0;
            case (bst_q)
               B_ADDR: begin
                  rw_d = sh_q[0];
                  if (sh_q[7:1] != DEV_ADDR) begin
                     bst_d  = B_IDLE;
                     ack_d  = 1'b0;
                     oe_n_d = 1'b1;
                  end
               end
               B_PTR:   ptr_d = sh_q;
               default: wr_en = 1'b1;
            endcase
         end else if (ack_q) begin
            ack_d  = 1'b0;
            oe_n_d = 1'b1;
            case (bst_q)
               B_ADDR: begin
                  bst_d = rw_q ? B_RD : B_PTR;
                  if (rw_q) begin
                     oe_n_d = rbyte[7];
                     sh_d   = {rbyte[6:0], 1'b0};
                     ptr_d  = ptr_q + 8'h01;
                  end
               end
               B_PTR:   bst_d = B_WR;
               default: ptr_d = ptr_q + 8'h01;
            endcase
         end
      end
   end

   always_ff @(posedge I_CLK) begin
      if (!I_RSTN || rst_all) begin
         bst_q  <= B_IDLE;
         bcnt_q <= '0;
         sh_q   <= '0;
         ptr_q  <= '0;
         ack_q  <= 1'b0;
         rw_q   <= 1'b0;
         oe_n_q <= 1'b1;
      end else begin
         bst_q  <= bst_d;
         bcnt_q <= bcnt_d;
         sh_q   <= sh_d;
         ptr_q  <= ptr_d;
         ack_q  <= ack_d;
         rw_q   <= rw_d;
         oe_n_q <= oe_n_d;
      end
   end

   // ***************************************************
   // register file
   // ***************************************************
   logic [7:0]        delay_q, delay_d;
   logic [CFG_W-1:0]  cfg_q, cfg_d;
   logic [LAT_W-1:0]  lat_q, lat_d;
   logic [REVT_W-1:0] revt_q, revt_d;

   wire wr_delay = wr_en & (ptr_q == ADDR_DELAY);
   wire wr_srst  = wr_en & (ptr_q == ADDR_SRST);
   wire wr_cfg   = wr_en & (ptr_q == ADDR_CFG);
   wire wr_evt   = wr_en & (ptr_q == ADDR_EVT);
   wire wr_e01   = wr_en & (ptr_q == ADDR_EVT01);
   wire wr_e23   = wr_en & (ptr_q == ADDR_EVT23);

   wire [LAT_W-1:0]  lat_set  = {sd_live, warn_live, rst_evt, load_rise};
   wire [LAT_W-1:0]  lat_clr  = wr_evt ? sh_q[LAT_W-1:0] : '0;
   wire [REVT_W-1:0] revt_clr = {wr_e23 & sh_q[RE_ILIM_B], wr_e23 & sh_q[RE_ILIM_A],
                                 wr_e01 & sh_q[RE_ILIM_B], wr_e01 & sh_q[RE_PG],
                                 wr_e01 & sh_q[RE_SC],     wr_e01 & sh_q[RE_ILIM_A]};
   // summary per rail, live from the rail event bits
   wire [3:0] rail_pend = {revt_q[5], revt_q[4], revt_q[3], |revt_q[2:0]};

   always_comb begin
      delay_d     = wr_delay ? sh_q : delay_q;
      cfg_d       = wr_cfg ? sh_q[CFG_W-1:0] : cfg_q;
      srst_pend_d = srst_pend_q | (wr_srst & sh_q[SRST_BIT]);
      lat_d       = (lat_q & ~lat_clr) | lat_set;
      revt_d      = (revt_q & ~revt_clr) | rise[SY_REVT +: REVT_W];
      if (rst_all) begin
         delay_d     = DELAY_RST;
         cfg_d       = CFG_RST;
         srst_pend_d = 1'b0;
         lat_d       = lat_set;
         revt_d      = '0;
      end
   end

   always_ff @(posedge I_CLK) begin
      if (!I_RSTN) begin
         delay_q     <= DELAY_RST;
         cfg_q       <= CFG_RST;
         srst_pend_q <= 1'b0;
         lat_q       <= '0;
         revt_q      <= '0;
      end else begin
         delay_q     <= delay_d;
         cfg_q       <= cfg_d;
         srst_pend_q <= srst_pend_d;
         lat_q       <= lat_d;
         revt_q      <= revt_d;
      end
   end

   // read data; command bit always reads zero
   always_comb begin
      rbyte = 8'h00;
      case (ptr_q)
         ADDR_DELAY: rbyte = delay_q;
         ADDR_CFG:   rbyte[CFG_W-1:0] = cfg_q;
         ADDR_EVT:   rbyte = {rail_pend, lat_q};
         ADDR_EVT01: begin
            rbyte[RE_ILIM_A] = revt_q[0];
            rbyte[RE_SC]     = revt_q[1];
            rbyte[RE_PG]     = revt_q[2];
            rbyte[RE_ILIM_B] = revt_q[3];
         end
         ADDR_EVT23: begin
            rbyte[RE_ILIM_A] = revt_q[4];
            rbyte[RE_ILIM_B] = revt_q[5];
         end
         ADDR_STAT: begin
            rbyte[STAT_SD]   = sd_live;
            rbyte[STAT_WARN] = warn_live;
         end
         default:    rbyte = 8'h00;
      endcase
   end

   // ***************************************************
   // main rail sequencing
   // ***************************************************
   pmtc_rail_e         rst_q, rst_d;
   logic [PRESC_W-1:0] presc_q, presc_d;
   logic [DLY_W-1:0]   ms_q, ms_d;

   wire              sd_block = lat_q[EVT_SD];
   wire [DLY_W-1:0]  on_dly   = delay_q[ON_DLY_LSB +: DLY_W];
   wire [DLY_W-1:0]  off_dly  = delay_q[OFF_DLY_LSB +: DLY_W];
   wire              ms_tick  = (presc_q == MS_LAST);

   always_comb begin
      rst_d   = rst_q;
      presc_d = ms_tick ? '0 : presc_q + PRESC_W'(1);
      ms_d    = (ms_tick && ms_q != '1) ? ms_q + DLY_W'(1) : ms_q;
      case (rst_q)
         R_OFF:      if (en_s && !sd_block) rst_d = R_ON_WAIT;
         R_ON_WAIT:  if (!en_s || sd_block) rst_d = R_OFF;
                     else if (ms_q == on_dly) rst_d = R_ON;
         R_ON:       if (sd_block) rst_d = R_OFF;
                     else if (!en_s) rst_d = R_OFF_WAIT;
         R_OFF_WAIT: if (sd_block) rst_d = R_OFF;
                     else if (en_s) rst_d = R_ON;
                     else if (ms_q == off_dly) rst_d = R_OFF;
         default:    rst_d = R_OFF;
      endcase
      if (rst_all) begin
         rst_d = R_OFF;
      end
      if (rst_d != rst_q) begin
         presc_d = '0;
         ms_d    = '0;
      end
   end

   always_ff @(posedge I_CLK) begin
      if (!I_RSTN) begin
         rst_q          <= R_OFF;
         presc_q        <= '0;
         ms_q           <= '0;
         O_MAIN_RAIL_EN <= 1'b0;
      end else begin
         rst_q          <= rst_d;
         presc_q        <= presc_d;
         ms_q           <= ms_d;
         O_MAIN_RAIL_EN <= (rst_d == R_ON) || (rst_d == R_OFF_WAIT);
      end
   end

   // ***************************************************
   // registered outputs
   // ***************************************************
   always_ff @(posedge I_CLK) begin
      if (!I_RSTN) begin
         O_SDA_OUT     <= 1'b0;
         O_SDA_OE_N    <= 1'b1;
         O_EN_PIN1_PD  <= CFG_RST[CFG_PD1];
         O_EN_PIN2_PD  <= CFG_RST[CFG_PD2];
         O_OT_WARN_SEL <= CFG_RST[CFG_WSEL];
         O_SPREAD_EN   <= CFG_RST[CFG_SPREAD];
      end else begin
         O_SDA_OUT     <= 1'b0;
         O_SDA_OE_N    <= oe_n_q;
         O_EN_PIN1_PD  <= cfg_q[CFG_PD1];
         O_EN_PIN2_PD  <= cfg_q[CFG_PD2];
         O_OT_WARN_SEL <= cfg_q[CFG_WSEL];
         O_SPREAD_EN   <= cfg_q[CFG_SPREAD];
      end
   end

endmodule : pmtc_top

// >>> testbench/pmtc_top_sva.sv
// checker for the top control block pins
module pmtc_top_sva #(
   parameter int unsigned MS_CYCLES_P = 20
) (
   input wire logic I_CLK,
   input wire logic I_RSTN,
   input wire logic I_SCL,
   input wire logic I_EN_PIN1,
   input wire logic I_ANALOG_UV,
   input wire logic I_OT_SD_LIVE,
   input wire logic I_OT_WARN_LIVE,
   input wire logic O_SDA_OE_N,
   input wire logic O_MAIN_RAIL_EN,
   input wire logic O_EN_PIN1_PD,
   input wire logic O_EN_PIN2_PD
);
   timeunit 1ns;
   timeprecision 1ps;
   // longest off delay plus sync margin
   localparam int LIM = 15 * MS_CYCLES_P + 12;
   int lo_cnt_q;
   always_ff @(posedge I_CLK) begin
      if (!I_RSTN || I_EN_PIN1) lo_cnt_q <= 0;
      else if (lo_cnt_q < LIM) lo_cnt_q <= lo_cnt_q + 1;
   end
   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (!I_RSTN);
   property p_sd_off;
      $rose(I_OT_SD_LIVE) |-> ##[1:6] !O_MAIN_RAIL_EN;
   endproperty
   a_sd_off: assert property (p_sd_off) else $error("rail on after overtemp");
   property p_hot_hold;
      I_OT_SD_LIVE [*6] |-> !O_MAIN_RAIL_EN;
   endproperty
   a_hot_hold: assert property (p_hot_hold) else $error("rail on while hot");
   property p_on_cause;
      $rose(O_MAIN_RAIL_EN) |-> $past(I_EN_PIN1, 3);
   endproperty
   a_on_cause: assert property (p_on_cause) else $error("rail on without enable");
   property p_off_bound;
      lo_cnt_q >= LIM |-> !O_MAIN_RAIL_EN;
   endproperty
   a_off_bound: assert property (p_off_bound) else $error("rail on past off delay");
   property p_rst_dflt;
      $rose(I_RSTN) |-> O_EN_PIN1_PD && O_EN_PIN2_PD && !O_MAIN_RAIL_EN;
   endproperty
   a_rst_dflt: assert property (p_rst_dflt) else $error("bad pin state at reset");
   property p_uv_dflt;
      $rose(I_ANALOG_UV) |-> ##[1:6] (!O_MAIN_RAIL_EN && O_EN_PIN1_PD && O_EN_PIN2_PD);
   endproperty
   a_uv_dflt: assert property (p_uv_dflt) else $error("undervoltage not reset");
   property p_sda_low;
      $changed(O_SDA_OE_N) |-> !I_SCL;
   endproperty
   a_sda_low: assert property (p_sda_low) else $error("data moved with clock high");
   property p_warn_keep;
      $rose(I_OT_WARN_LIVE) && O_MAIN_RAIL_EN && I_EN_PIN1 && !I_OT_SD_LIVE
         |=> O_MAIN_RAIL_EN;
   endproperty
   a_warn_keep: assert property (p_warn_keep) else $error("warning dropped rail");
   c_rail_on: cover property ($rose(O_MAIN_RAIL_EN));
   c_sd: cover property ($rose(I_OT_SD_LIVE) ##[1:6] !O_MAIN_RAIL_EN);
   c_uv: cover property ($rose(I_ANALOG_UV));
endmodule : pmtc_top_sva

bind pmtc_top pmtc_top_sva #(.MS_CYCLES_P(MS_CYCLES_P)) i_sva (
   .I_CLK, .I_RSTN, .I_SCL, .I_EN_PIN1, .I_ANALOG_UV, .I_OT_SD_LIVE, .I_OT_WARN_LIVE,
   .O_SDA_OE_N, .O_MAIN_RAIL_EN, .O_EN_PIN1_PD, .O_EN_PIN2_PD
);

// >>> testbench/pmtc_host.sv
// two-wire host model, 80 ns bit period
module pmtc_host (
   input  wire logic i_clk,
   input  wire logic i_sda,
   output logic      o_scl,
   output logic      o_sda_low
);
   timeunit 1ns;
   timeprecision 1ps;
   import pmtc_pkg::*;
   // clock idles high between frames
   initial begin
      o_scl = 1'b1;
      o_sda_low = 1'b0;
   end
   task automatic put(input logic b);
      #20 o_sda_low = !b;
      #20 o_scl = 1'b1;
      #40 o_scl = 1'b0;
   endtask : put
   // released line reads the pull-up level
   task automatic get(output logic b);
      #20 o_sda_low = 1'b0;
      #20 o_scl = 1'b1;
      #20 b = i_sda;
      #20 o_scl = 1'b0;
   endtask : get
   task automatic start;
      @(posedge i_clk) #1 o_sda_low = 1'b0;
      #20 o_scl = 1'b1;
      #20 o_sda_low = 1'b1;
      #20 o_scl = 1'b0;
   endtask : start
   task automatic stop;
      #20 o_sda_low = 1'b1;
      #20 o_scl = 1'b1;
      #40 o_sda_low = 1'b0;
      #40;
   endtask : stop
   task automatic send(input logic [7:0] d, output logic nak);
      for (int i = 7; i >= 0; i--) put(d[i]);
      get(nak);
   endtask : send
   task automatic xfer_wr(input logic [6:0] dev, input logic [7:0] a, d, output logic ok);
      logic k0, k1, k2;
      start;
      send({dev, 1'b0}, k0);
      send(a, k1);
      send(d, k2);
      stop;
      ok = !(k0 | k1 | k2);
   endtask : xfer_wr
   task automatic xfer_rd(input logic [7:0] a, output logic [7:0] d);
      logic k;
      start;
      send({DEV_ADDR, 1'b0}, k);
      send(a, k);
      start;
      send({DEV_ADDR, 1'b1}, k);
      for (int i = 7; i >= 0; i--) get(d[i]);
      put(1'b1);
      stop;
   endtask : xfer_rd
endmodule : pmtc_host

// >>> testbench/test_pmtc_top.sv
// testbench for the top control block
module test_pmtc_top;
   timeunit 1ns;
   timeprecision 1ps;
   import pmtc_pkg::*;
   localparam int MSC = 20;
   localparam logic [7:0] EREG [6] = '{8'h19, 8'h19, 8'h19, 8'h19, 8'h1a, 8'h1a};
   localparam logic [7:0] EBIT [6] = '{8'h01, 8'h02, 8'h04, 8'h10, 8'h01, 8'h10};
   localparam logic [7:0] ESUM [6] = '{8'h10, 8'h10, 8'h10, 8'h20, 8'h40, 8'h80};
   localparam logic [7:0] DLY [2] = '{8'h32, 8'h0f};
   logic clk = 1'b0, rstn = 1'b0, en = 1'b0, uv = 1'b0, sd = 1'b0, wrn = 1'b0, ld = 1'b0;
   logic [REVT_W-1:0] evt = '0;
   logic scl, sda_low, sda_out, oe_n, rail, pd1, pd2, wsel, spr, ack_ok;
   wire logic sda_w = ~(sda_low | ~oe_n);
   int n_fail = 0;
   int tests_run = 0;
   always #2 clk = ~clk;
   pmtc_top #(.MS_CYCLES_P(MSC)) i_dut (
      .I_CLK(clk), .I_RSTN(rstn), .I_SCL(scl), .I_SDA_IN(sda_w), .O_SDA_OUT(sda_out),
      .O_SDA_OE_N(oe_n), .I_EN_PIN1(en), .I_ANALOG_UV(uv), .I_OT_SD_LIVE(sd),
      .I_OT_WARN_LIVE(wrn), .I_LOAD_DONE(ld), .I_RAIL_EVT(evt), .O_MAIN_RAIL_EN(rail),
      .O_EN_PIN1_PD(pd1), .O_EN_PIN2_PD(pd2), .O_OT_WARN_SEL(wsel), .O_SPREAD_EN(spr)
   );
   pmtc_host i_host (.i_clk(clk), .i_sda(sda_w), .o_scl(scl), .o_sda_low(sda_low));
   task automatic chk(input logic [7:0] got, exp);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic tally_and_finish;
      if (n_fail == 0 && tests_run > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : tally_and_finish
   task automatic wr(input logic [7:0] a, d);
      logic ok;
      i_host.xfer_wr(DEV_ADDR, a, d, ok);
      chk({7'h0, ok}, 8'h01);
   endtask : wr
   task automatic rc(input logic [7:0] a, exp);
      logic [7:0] d;
      i_host.xfer_rd(a, d);
      chk(d, exp);
   endtask : rc
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : cyc
   task automatic wait_rail(input logic v, input int lo, hi);
      int n;
      n = 0;
      while (rail !== v) begin
         cyc(1);
         n++;
         if (n > hi) begin
            n_fail++;
            tally_and_finish;
         end
      end
      chk({7'h0, n >= lo}, 8'h01);
   endtask : wait_rail
   initial begin
      cyc(10);
      rstn = 1'b1;
      chk({5'h0, sda_out, pd2, pd1}, 8'h03);
      rc(ADDR_DELAY, DELAY_RST);
      rc(ADDR_SRST, 8'h00);
      rc(ADDR_CFG, {4'h0, CFG_RST});
      rc(ADDR_EVT, 8'h02);
      wr(ADDR_EVT, 8'h00);
      rc(ADDR_EVT, 8'h02);
      wr(ADDR_EVT, 8'h02);
      rc(ADDR_EVT, 8'h00);
      wr(ADDR_CFG, 8'hf9);
      rc(ADDR_CFG, 8'h09);
      chk({4'h0, wsel, pd2, pd1, spr}, 8'h09);
      wr(8'h20, 8'h5a);
      rc(8'h20, 8'h00);
      i_host.xfer_wr(7'h2b, ADDR_CFG, 8'h00, ack_ok);
      chk({7'h0, ack_ok}, 8'h00);
      rc(ADDR_CFG, 8'h09);
      foreach (DLY[i]) begin
         wr(ADDR_DELAY, DLY[i]);
         en = 1'b1;
         wait_rail(1'b1, DLY[i][3:0] * MSC, DLY[i][3:0] * MSC + 10);
         cyc(1);
         en = 1'b0;
         wait_rail(1'b0, DLY[i][7:4] * MSC, DLY[i][7:4] * MSC + 10);
      end
      wr(ADDR_DELAY, 8'h00);
      en = 1'b1;
      wait_rail(1'b1, 0, 10);
      cyc(1);
      sd = 1'b1;
      wait_rail(1'b0, 0, 8);
      rc(ADDR_STAT, 8'h08);
      wr(ADDR_EVT, 8'h08);
      rc(ADDR_EVT, 8'h08);
      sd = 1'b0;
      en = 1'b0;
      cyc(10);
      en = 1'b1;
      cyc(40);
      chk({7'h0, rail}, 8'h00);
      rc(ADDR_EVT, 8'h08);
      wr(ADDR_EVT, 8'h08);
      rc(ADDR_EVT, 8'h00);
      en = 1'b0;
      cyc(10);
      en = 1'b1;
      wait_rail(1'b1, 0, 10);
      wrn = 1'b1;
      cyc(10);
      rc(ADDR_STAT, 8'h04);
      wrn = 1'b0;
      rc(ADDR_EVT, 8'h04);
      chk({7'h0, rail}, 8'h01);
      wr(ADDR_EVT, 8'h04);
      ld = 1'b1;
      cyc(5);
      ld = 1'b0;
      rc(ADDR_EVT, 8'h01);
      wr(ADDR_EVT, 8'h01);
      rc(ADDR_EVT, 8'h00);
      foreach (EREG[i]) begin
         evt[i] = 1'b1;
         cyc(6);
         evt[i] = 1'b0;
         rc(ADDR_EVT, ESUM[i]);
         rc(EREG[i], EBIT[i]);
         wr(EREG[i], EBIT[i]);
         rc(ADDR_EVT, 8'h00);
      end
      en = 1'b0;
      wr(ADDR_DELAY, 8'h55);
      wr(ADDR_SRST, 8'h01);
      rc(ADDR_SRST, 8'h00);
      rc(ADDR_DELAY, DELAY_RST);
      rc(ADDR_CFG, 8'h06);
      rc(ADDR_EVT, 8'h02);
      wr(ADDR_EVT, 8'h02);
      wr(ADDR_CFG, 8'h00);
      uv = 1'b1;
      cyc(6);
      uv = 1'b0;
      rc(ADDR_CFG, 8'h06);
      rc(ADDR_EVT, 8'h02);
      tally_and_finish;
   end
endmodule : test_pmtc_top
